// >>> core/char_shifter.sv
`timescale 1ns/10ps
`default_nettype none
module char_shifter
	import spi_master_port_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// control
	input wire logic load,
	input wire logic [4:0] len_m1,
	input wire logic [31:0] data,
	input wire logic cpha,
	input wire logic launch,
	input wire logic sample,
	// serial
	input wire logic rx_in,
	output logic tx_bit,
	output logic [31:0] rx_word
);
	logic [31:0] sh_q;
	logic [31:0] aligned;

	// msb first: move the character to the top of the register
	assign aligned = data << (5'd31 - len_m1);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sh_q <= 32'h0000_0000;
			tx_bit <= 1'b0;
		end else if (load) begin
			if (!cpha) begin
				tx_bit <= aligned[31];
				sh_q <= aligned << 1;
			end else begin
				sh_q <= aligned;
			end
		end else if (launch) begin
			tx_bit <= sh_q[31];
			sh_q <= sh_q << 1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_word <= 32'h0000_0000;
		end else if (load) begin
			rx_word <= 32'h0000_0000;
		end else if (sample) begin
			rx_word <= {rx_word[30:0], rx_in};
		end
	end
endmodule
`default_nettype wire

// >>> core/half_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
module half_tick_gen
	import spi_master_port_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// control
	input wire logic run,
	input wire logic [15:0] div,
	// half-period strobe
	output logic tick
);
	logic [15:0] cnt_q;
	logic [15:0] limit;

	// at least two system clocks per half period
	assign limit = (div < HALF_LIMIT_MIN) ? HALF_LIMIT_MIN : div;
	assign tick = run && (cnt_q >= limit);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 16'h0000;
		end else if (!run || tick) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// >>> core/spi_master_port.sv
`timescale 1ns/10ps
`default_nettype none
module spi_master_port
	import spi_master_port_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link
	output logic serial_clk,
	output logic [3:0] chip_select_pins,
	output logic serial_tx,
	input wire logic serial_rx,
	// interrupt
	output logic irq
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [15:0] clk_div_q;
	logic [15:0] clk_ctrl_q;
	logic [31:0] dev_cfg_q;
	logic [15:0] cmd_lo_q;
	logic [15:0] cmd_hi_q;
	logic [31:0] tx_data_q;
	logic [31:0] rx_data_q;
	logic tx_pending_q;
	logic [1:0] int_stat_q;
	logic [1:0] int_mask_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;

	xfer_state_e state_q;
	logic [5:0] edge_q;
	logic [2:0] lead_q;
	logic [11:0] left_q;
	logic [11:0] done_cnt_q;
	logic [1:0] cur_cs_q;
	logic [4:0] cur_len_q;
	logic cur_cpol_q;
	logic cur_cpha_q;
	logic cur_cshi_q;
	logic sclk_q;
	logic [3:0] cs_q;
	logic char_end_q;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic acc;
	logic wr;
	logic hit;
	logic [31:0] rd_mux;

	assign acc = psel && penable && pready_q;
	assign wr = acc && pwrite && hit;

	always_comb begin
		hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			A_CLK_DIV: rd_mux[15:0] = clk_div_q;
			A_CLK_CTRL: rd_mux[15:0] = clk_ctrl_q;
			A_DEV_CFG_LO: rd_mux[15:0] = dev_cfg_q[15:0];
			A_DEV_CFG_HI: rd_mux[15:0] = dev_cfg_q[31:16];
			A_CMD_LO: rd_mux[15:0] = cmd_lo_q;
			A_CMD_HI: rd_mux[15:0] = cmd_hi_q;
			A_STAT_LO: begin
				rd_mux[ST_BUSY] = (state_q != S_IDLE);
				rd_mux[ST_WAITDATA] = (state_q == S_WAIT);
			end
			A_STAT_HI: rd_mux[11:0] = done_cnt_q;
			A_DATA_LO: rd_mux[15:0] = rx_data_q[15:0];
			A_DATA_HI: rd_mux[15:0] = rx_data_q[31:16];
			A_INT_STAT: rd_mux[1:0] = int_stat_q;
			A_INT_MASK: rd_mux[1:0] = int_mask_q;
			default: hit = 1'b0;
		endcase
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (psel && penable && !pready_q) begin
			pready_q <= 1'b1;
			pslverr_q <= !hit;
			prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			clk_div_q <= CLK_DIV_RST;
			clk_ctrl_q <= CLK_CTRL_RST;
			dev_cfg_q <= DEV_CFG_RST;
			cmd_lo_q <= CMD_LO_RST;
			cmd_hi_q <= CMD_HI_RST;
			int_mask_q <= 2'h0;
		end else if (wr) begin
			case (paddr)
				A_CLK_DIV: clk_div_q <= pwdata[15:0];
				A_CLK_CTRL: clk_ctrl_q <= pwdata[15:0];
				A_DEV_CFG_LO: dev_cfg_q[15:0] <= pwdata[15:0];
				A_DEV_CFG_HI: dev_cfg_q[31:16] <= pwdata[15:0];
				A_CMD_LO: cmd_lo_q <= pwdata[15:0];
				A_CMD_HI: cmd_hi_q <= {pwdata[15:9], 1'b0, pwdata[7:0]};
				A_INT_MASK: int_mask_q <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_data_q <= 32'h0000_0000;
		end else if (wr && paddr == A_DATA_LO) begin
			tx_data_q[15:0] <= pwdata[15:0];
		end else if (wr && paddr == A_DATA_HI) begin
			tx_data_q[31:16] <= pwdata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// transfer engine
	// ----------------------------------------------------------------
	logic tick;
	logic start;
	logic load;
	logic leading;
	logic launch;
	logic sample;
	logic last_edge;
	logic [7:0] sel_cfg;
	logic [31:0] rx_word;
	logic tx_bit;

	assign sel_cfg = dev_cfg_q[pwdata[CMDH_CS +: 2] * DCFG_STRIDE +: 8];
	assign start = wr && paddr == A_CMD_HI && pwdata[CMDH_START] && clk_ctrl_q[CTRL_EN]
		&& state_q == S_IDLE;
	assign load = state_q == S_WAIT && tx_pending_q;
	assign leading = !edge_q[0];
	assign last_edge = edge_q == {cur_len_q, 1'b1};
	assign launch = state_q == S_SHIFT && tick
		&& (cur_cpha_q ? leading : (!leading && !last_edge));
	assign sample = state_q == S_SHIFT && tick && (cur_cpha_q ? !leading : leading);

	half_tick_gen u_tick (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.run(state_q != S_IDLE),
		.div(clk_div_q),
		.tick(tick)
	);

	char_shifter u_shift (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.load(load),
		.len_m1(cur_len_q),
		.data(tx_data_q),
		.cpha(cur_cpha_q),
		.launch(launch),
		.sample(sample),
		.rx_in(serial_rx),
		.tx_bit(tx_bit),
		.rx_word(rx_word)
	);

	// a write to the upper data half marks a character ready to send
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_pending_q <= 1'b0;
		end else if (wr && paddr == A_DATA_HI) begin
			tx_pending_q <= 1'b1;
		end else if (load) begin
			tx_pending_q <= 1'b0;
		end
	end

	// settings of the selected device are frozen for the frame
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_cs_q <= 2'h0;
			cur_len_q <= 5'h1F;
			cur_cpol_q <= 1'b0;
			cur_cpha_q <= 1'b0;
			cur_cshi_q <= 1'b0;
		end else if (start) begin
			cur_cs_q <= pwdata[CMDH_CS +: 2];
			cur_len_q <= pwdata[CMDH_CLEN +: 5];
			cur_cpol_q <= sel_cfg[DCFG_CPOL];
			cur_cpha_q <= sel_cfg[DCFG_CPHA];
			cur_cshi_q <= sel_cfg[DCFG_CSHI];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= S_IDLE;
			edge_q <= 6'h00;
			lead_q <= 3'h0;
			left_q <= 12'h000;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (start) begin
						state_q <= S_LEAD;
						// one base clock cycle plus the programmed delay
						lead_q <= {sel_cfg[DCFG_DLY +: 2], 1'b1};
						left_q <= cmd_lo_q[11:0];
					end
				end
				S_LEAD: begin
					if (tick) begin
						if (lead_q == 3'h0) begin
							state_q <= S_WAIT;
						end else begin
							lead_q <= lead_q - 3'h1;
						end
					end
				end
				S_WAIT: begin
					if (load) begin
						state_q <= S_SHIFT;
						edge_q <= 6'h00;
					end
				end
				S_SHIFT: begin
					if (tick) begin
						edge_q <= edge_q + 6'h01;
						if (last_edge) begin
							if (left_q == 12'h000) begin
								state_q <= S_TRAIL;
							end else begin
								left_q <= left_q - 12'h001;
								state_q <= S_WAIT;
							end
						end
					end
				end
				S_TRAIL: begin
					if (tick) begin
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// serial pins
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_q <= 1'b0;
		end else if (state_q == S_SHIFT && tick) begin
			sclk_q <= !sclk_q;
		end else if (state_q != S_SHIFT) begin
			sclk_q <= start ? sel_cfg[DCFG_CPOL] : cur_cpol_q;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_q <= CS_IDLE_RST;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (state_q != S_IDLE && cur_cs_q == 2'(i)) begin
					cs_q[i] <= cur_cshi_q;
				end else begin
					cs_q[i] <= !dev_cfg_q[i * DCFG_STRIDE + DCFG_CSHI];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// completion, status and interrupt
	// ----------------------------------------------------------------
	logic [1:0] int_set;
	logic [1:0] int_clr;

	assign int_set[INT_CHAR] = char_end_q;
	assign int_set[INT_FRAME] = state_q == S_TRAIL && tick;
	assign int_clr = (wr && paddr == A_INT_STAT) ? pwdata[1:0] : 2'h0;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			char_end_q <= 1'b0;
			rx_data_q <= 32'h0000_0000;
			done_cnt_q <= 12'h000;
		end else begin
			char_end_q <= state_q == S_SHIFT && tick && last_edge;
			if (char_end_q) begin
				rx_data_q <= rx_word;
				done_cnt_q <= done_cnt_q + 12'h001;
			end else if (start) begin
				done_cnt_q <= 12'h000;
			end
		end
	end

	// set wins over a simultaneous clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			int_stat_q <= 2'h0;
		end else begin
			int_stat_q <= (int_stat_q & ~int_clr) | int_set;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(int_stat_q & int_mask_q);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign serial_clk = sclk_q;
	assign chip_select_pins = cs_q;
	assign serial_tx = tx_bit;
	assign irq = irq_q;
endmodule
`default_nettype wire

// >>> core/spi_master_port_pkg.sv
package spi_master_port_pkg;

	// ----------------------------------------------------------------
	// register indices and byte addresses (byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_CLK_DIV = 16'h3000;
	localparam logic [15:0] IDX_CLK_CTRL = 16'h3001;
	localparam logic [15:0] IDX_DEV_CFG_LO = 16'h3002;
	localparam logic [15:0] IDX_DEV_CFG_HI = 16'h3003;
	localparam logic [15:0] IDX_CMD_LO = 16'h3004;
	localparam logic [15:0] IDX_CMD_HI = 16'h3005;
	localparam logic [15:0] IDX_STAT_LO = 16'h3006;
	localparam logic [15:0] IDX_STAT_HI = 16'h3007;
	localparam logic [15:0] IDX_DATA_LO = 16'h3008;
	localparam logic [15:0] IDX_DATA_HI = 16'h3009;
	localparam logic [15:0] IDX_INT_STAT = 16'h300A;
	localparam logic [15:0] IDX_INT_MASK = 16'h300B;

	localparam logic [15:0] A_CLK_DIV = IDX_CLK_DIV << 2;
	localparam logic [15:0] A_CLK_CTRL = IDX_CLK_CTRL << 2;
	localparam logic [15:0] A_DEV_CFG_LO = IDX_DEV_CFG_LO << 2;
	localparam logic [15:0] A_DEV_CFG_HI = IDX_DEV_CFG_HI << 2;
	localparam logic [15:0] A_CMD_LO = IDX_CMD_LO << 2;
	localparam logic [15:0] A_CMD_HI = IDX_CMD_HI << 2;
	localparam logic [15:0] A_STAT_LO = IDX_STAT_LO << 2;
	localparam logic [15:0] A_STAT_HI = IDX_STAT_HI << 2;
	localparam logic [15:0] A_DATA_LO = IDX_DATA_LO << 2;
	localparam logic [15:0] A_DATA_HI = IDX_DATA_HI << 2;
	localparam logic [15:0] A_INT_STAT = IDX_INT_STAT << 2;
	localparam logic [15:0] A_INT_MASK = IDX_INT_MASK << 2;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_EN = 0;
	localparam int unsigned DCFG_STRIDE = 8;
	localparam int unsigned DCFG_CPOL = 0;
	localparam int unsigned DCFG_CPHA = 1;
	localparam int unsigned DCFG_CSHI = 2;
	localparam int unsigned DCFG_DLY = 3;
	localparam int unsigned CMDH_CS = 0;
	localparam int unsigned CMDH_CLEN = 2;
	localparam int unsigned CMDH_START = 8;
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_WAITDATA = 1;
	localparam int unsigned INT_CHAR = 0;
	localparam int unsigned INT_FRAME = 1;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [15:0] CLK_DIV_RST = 16'h0003;
	localparam logic [15:0] CLK_CTRL_RST = 16'h0000;
	localparam logic [31:0] DEV_CFG_RST = 32'h0000_0000;
	localparam logic [15:0] CMD_LO_RST = 16'h0000;
	localparam logic [15:0] CMD_HI_RST = 16'h001C;
	localparam logic [3:0] CS_IDLE_RST = 4'hF;
	localparam logic [15:0] HALF_LIMIT_MIN = 16'h0001;

	typedef enum logic [2:0] {
		S_IDLE,
		S_LEAD,
		S_WAIT,
		S_SHIFT,
		S_TRAIL
	} xfer_state_e;

endpackage

// >>> verif/spi_master_port_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module spi_master_port_assertions (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// serial and interrupt
	input wire logic serial_clk,
	input wire logic [3:0] chip_select_pins,
	input wire logic serial_tx,
	input wire logic serial_rx,
	input wire logic irq
);
	// ---
	// bus and link checks
	// ---
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_reset_idle: assert property ($rose(arst_n) |->
		!serial_clk && chip_select_pins == 4'hF && !irq) else $error("bad idle after reset");
	a_sclk_half_min: assert property ($changed(serial_clk) |=> $stable(serial_clk))
		else $error("serial clock half period too short");
	a_cs_held_clk: assert property ($changed(serial_clk) && !$past(pready) &&
		!$past(pready, 2) && !$past(pready, 3) |-> $stable(chip_select_pins) [*2])
		else $error("select moved next to a clock edge");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_second: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("ready not in second access cycle");
	a_ready_needs_req: assert property (pready |-> $past(psel) && $past(penable))
		else $error("ready without request");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_err_reads_zero: assert property (pslverr |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
		else $error("upper read half not zero");
	cover property ($changed(serial_clk));
	cover property (pslverr);
	cover property ($rose(irq));
endmodule
bind spi_master_port spi_master_port_assertions spi_master_port_assertions_inst (
	.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.serial_clk(serial_clk), .chip_select_pins(chip_select_pins), .serial_tx(serial_tx),
	.serial_rx(serial_rx), .irq(irq));
`default_nettype wire

// >>> verif/spi_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
	// clock
	input wire logic core_clk,
	// link
	input wire logic sel,
	input wire logic sclk,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic tx,
	output logic rx,
	// character setup and capture
	input wire logic [5:0] len,
	input wire logic [31:0] reply,
	output logic [31:0] cap
);
	// ---
	// shifts reply out msb first, captures tx on sample edges
	// ---
	logic sc_q, sel_q;
	logic [5:0] cnt_q;
	initial rx = 1'b0;
	always @(posedge core_clk) begin
		sc_q <= sclk;
		sel_q <= sel;
		if (!sel) begin
			// released line keeps moving so a stale bit is never read
			rx <= ~rx;
			cnt_q <= 6'h0;
		end else if (!sel_q) begin
			if (!cpha)
				rx <= reply[len - 6'h1];
		end else if (sclk !== sc_q) begin
			if (sclk == !(cpol ^ cpha)) begin
				cap <= {cap[30:0], tx};
				cnt_q <= (cnt_q == len - 6'h1) ? 6'h0 : cnt_q + 6'h1;
			end else
				rx <= reply[len - 6'h1 - cnt_q];
		end
	end
endmodule
`default_nettype wire

// >>> verif/test_spi_master_port.sv
`timescale 1ns/10ps
`default_nettype none
module test_spi_master_port
	import spi_master_port_pkg::*;
;
	logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
	logic serial_clk, serial_tx, serial_rx, irq, cpol, cpha, cshi, sc_q;
	logic [15:0] paddr, div;
	logic [31:0] pwdata, prdata, rd, w, reply, tx, cap, cfg;
	logic [3:0] chip_select_pins;
	logic [1:0] dev, dly;
	logic [5:0] len;
	int errors, n_compared, tog, lead, half, n;
	wire sel = chip_select_pins[dev] === cshi;
	spi_master_port spi_master_port_inst (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_clk(serial_clk), .irq(irq),
		.chip_select_pins(chip_select_pins), .serial_tx(serial_tx), .serial_rx(serial_rx));
	spi_slave_model spi_slave_model_inst (.core_clk(core_clk), .sel(sel), .sclk(serial_clk),
		.cpol(cpol), .cpha(cpha), .tx(serial_tx), .rx(serial_rx), .len(len), .reply(reply),
		.cap(cap));
	// ---
	// helpers
	// ---
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (sel && serial_clk !== sc_q)
			tog++;
		if (sel && tog == 0)
			lead++;
		sc_q = serial_clk;
	end
	function automatic logic [31:0] msk(input logic [5:0] k);
		return 32'hFFFFFFFF >> (6'd32 - k);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wait_for(input logic v);
		n = 0;
		while ((v ? sel : irq) !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ---
	// tests
	// ---
	initial begin
		#3000000;
		errors++;
		give_verdict();
	end
	initial begin
		{arst_n, psel, penable, pwrite, paddr, pwdata, dev, cshi, cpol, cpha} = '0;
		{errors, n_compared, tog, lead, sc_q, reply, len} = '0;
		void'($urandom(32'h8DD2));
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		chk({28'h0, chip_select_pins}, 32'hF);
		apb(0, A_CMD_HI, 0);
		chk(rd, 32'(CMD_HI_RST));
		apb(0, A_CLK_DIV, 0);
		chk(rd, 32'(CLK_DIV_RST));
		apb(0, 16'h0100, 0);
		chk({err, rd[30:0]}, 32'h80000000);
		apb(1, A_CMD_HI, 32'h100);
		repeat (8) @(posedge core_clk);
		chk({28'h0, chip_select_pins}, 32'hF);
		apb(1, A_CLK_CTRL, 1);
		apb(1, A_INT_MASK, 1);
		for (int i = 0; i < 9; i++) begin
			{cpol, cpha} = 2'(i);
			dev = 2'(i * 3);
			cshi = 1'($urandom);
			dly = (i == 1) ? 2'h3 : 2'($urandom);
			len = (i == 0) ? 6'd1 : (i == 1) ? 6'd32 : 6'(1 + $urandom_range(30));
			div = (i == 2) ? 16'h0 : 16'($urandom_range(3));
			half = (div > 1 ? div : 1) + 1;
			tx = $urandom;
			reply = $urandom;
			cfg = 32'({dly, cshi, cpha, cpol}) << (8 * dev);
			apb(1, A_CLK_DIV, 32'(div));
			apb(1, A_DEV_CFG_LO, cfg & 32'hFFFF);
			apb(1, A_DEV_CFG_HI, cfg >> 16);
			apb(1, A_CMD_LO, i == 8 ? 2 : 0);
			apb(1, A_DATA_LO, tx & 32'hFFFF);
			apb(1, A_DATA_HI, tx >> 16);
			tog = 0;
			lead = 0;
			apb(1, A_CMD_HI, 32'h100 | 32'(len - 1) << 2 | 32'(dev));
			wait_for(1);
			chk(32'(sel), 1);
			for (int k = 0; i == 8 && k < 3; k++) begin
				wait_for(0);
				chk({sel, irq}, 3);
				apb(1, A_INT_STAT, 1);
				@(posedge core_clk);
				chk(32'(irq), 0);
				apb(0, A_STAT_LO, 0);
				chk(rd, k < 2 ? 32'h3 : 32'h0);
				apb(1, A_DATA_HI, tx >> 16);
			end
			while (sel && n < 6000) begin
				@(posedge core_clk);
				n++;
			end
			chk(32'(tog), 32'(2 * len) * (i == 8 ? 3 : 1));
			chk(32'(lead >= 2 * half * (1 + dly) && lead <= 2 * half * (2 + dly) + 4), 1);
			chk(cap & msk(len), tx & msk(len));
			chk({serial_clk, chip_select_pins}, {cpol, 4'hF ^ (4'(cshi) << dev)});
			apb(0, A_DATA_LO, 0);
			w = rd;
			apb(0, A_DATA_HI, 0);
			chk({rd[15:0], w[15:0]} & msk(len), reply & msk(len));
			apb(0, A_INT_STAT, 0);
			chk(rd, i == 8 ? 32'h2 : 32'h3);
			chk(32'(irq), i == 8 ? 32'h0 : 32'h1);
			apb(1, A_INT_STAT, 3);
		end
		apb(0, A_STAT_HI, 0);
		chk(rd, 3);
		give_verdict();
	end
endmodule
`default_nettype wire
